// [pps_chk_sva.sv]
// Checker for the pre-boot sequencer, watching top-level ports only.
// Assumes one clock domain and the synchronous active-high reset.
`default_nettype none
module pps_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic es_part,
  input wire logic suspend_mode,
  input wire logic design_init_done,
  input wire logic cfg_rd_req,
  input wire logic [7:0] cfg_rd_addr,
  input wire logic thr_wr_en_a,
  input wire logic thr_wr_en_b,
  input wire logic flash_power_up,
  input wire logic boot_rom_loop,
  input wire logic core_reset,
  input wire logic boot_fail
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  rel_after_init_a: assert property ($fell(core_reset) |->
    flash_power_up && design_init_done)
    else $error("cores released before start-up finished");
  rst_clear_a: assert property ($fell(reset) |->
    core_reset && !boot_fail && !flash_power_up)
    else $error("reset state wrong after release");
  fail_sticky_a: assert property (
    boot_fail |=> boot_fail && core_reset)
    else $error("boot fail or held reset dropped");
  fail_held_a: assert property (
    boot_fail |-> core_reset && !boot_rom_loop)
    else $error("cores not held while boot fail set");
  cfg_pulse_a: assert property (cfg_rd_req |=> !cfg_rd_req)
    else $error("config read request longer than one cycle");
  cfg_addr_a: assert property (cfg_rd_req |-> cfg_rd_addr inside
    {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14})
    else $error("config read at unexpected offset");
  idle_quiet_a: assert property (
    boot_rom_loop |-> !cfg_rd_req && !core_reset)
    else $error("idle boot touched config or held cores");
  skip_a: assert property (es_part && suspend_mode && !flash_power_up
    |=> !flash_power_up)
    else $error("pre-boot started on suspended sample part");
  thr_excl_a: assert property (!(thr_wr_en_a && thr_wr_en_b))
    else $error("both threshold copies written at once");
endmodule // pps_chk
bind pps_preboot_seq pps_chk chk (.*);
`default_nettype wire

// [pps_defs.vh]
// Constants for the processor pre-boot sequencer.
// Assumes byte-addressed configuration and flash reads of 32-bit words.
`ifndef PPS_DEFS_VH
`define PPS_DEFS_VH
`define PPS_MODE_IDLE 2'h0
`define PPS_MODE_NONSEC 2'h1
`define PPS_MODE_USEC 2'h2
`define PPS_MODE_FSEC 2'h3
`define PPS_CFG_VEC0 8'h00
`define PPS_CFG_VEC1 8'h04
`define PPS_CFG_VEC2 8'h08
`define PPS_CFG_VEC3 8'h10
`define PPS_CFG_VEC4 8'h14
`define PPS_CFG_PAGE 8'h00
`define PPS_CFG_KEY 8'h04
`define PPS_CFG_CERT 8'h00
`define PPS_CFG_REVEN 8'h04
`define PPS_CERT_ADDR 8'h00
`define PPS_CERT_LEN 8'h04
`define PPS_CERT_VEC 8'h08
`define PPS_CERT_OPT 8'h1C
`define PPS_CERT_VER 8'h20
`define PPS_CERT_SER 8'h28
`define PPS_CERT_HASH 8'h38
`define PPS_CERT_SIG 8'h68
`define PPS_CERT_WORDS 8'h34
`define PPS_OPT_RAISE 0
`endif

// [pps_far.sv]
// Far-side model: config store, flash, helper engines, threshold store.
// Assumes one-cycle request pulses; answers after 1 or 8 cycles.
`default_nettype none
module pps_far (
  input wire logic clk,
  input wire logic slow,
  input wire logic auth_bad,
  input wire logic sig_bad,
  input wire logic cfg_rd_req,
  input wire logic [7:0] cfg_rd_addr,
  output logic cfg_rd_valid,
  output logic [31:0] boot_config_data,
  input wire logic flash_rd_req,
  input wire logic [31:0] flash_rd_addr,
  output logic flash_rd_valid,
  output logic [31:0] flash_rd_data,
  input wire logic flash_power_up,
  output logic flash_ready,
  input wire logic cache_repair_start,
  output logic cache_repair_done,
  input wire logic copy_start,
  output logic copy_done,
  input wire logic user_auth_start,
  output logic user_auth_done,
  output logic user_auth_fail,
  input wire logic sig_check_start,
  output logic sig_check_done,
  output logic sig_check_error,
  input wire logic thr_wr_en_a,
  input wire logic thr_wr_en_b,
  input wire logic [63:0] thr_wr_data,
  output logic thr_wr_done,
  output logic [63:0] thr_copy_a,
  output logic [63:0] thr_copy_b,
  output logic thr_valid_a,
  output logic thr_valid_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cfg [0:7];
  logic [31:0] fl [0:63];
  logic [31:0] cq, fq;
  logic [55:0] sh = '0;
  logic ea = 1'b0;
  logic eb = 1'b0;
  assign {cfg_rd_valid, flash_rd_valid, cache_repair_done, copy_done,
    user_auth_done, sig_check_done, thr_wr_done} = slow ? sh[55:49] : sh[6:0];
  // Outside the answer cycle the lines flip so stale data cannot pass
  assign boot_config_data = cfg_rd_valid ? cq : ~cq;
  assign flash_rd_data = flash_rd_valid ? fq : ~fq;
  assign user_auth_fail = user_auth_done ? auth_bad : ~auth_bad;
  assign sig_check_error = sig_check_done ? sig_bad : ~sig_bad;
  assign thr_valid_a = 1'b1;
  assign thr_valid_b = 1'b1;
  always @(posedge clk)
  begin
    ea <= thr_wr_en_a;
    eb <= thr_wr_en_b;
    flash_ready <= flash_power_up;
    sh <= {sh[48:0], cfg_rd_req, flash_rd_req, cache_repair_start,
      copy_start, user_auth_start, sig_check_start,
      (thr_wr_en_a & ~ea) | (thr_wr_en_b & ~eb)};
    if (cfg_rd_req)
      cq <= cfg[cfg_rd_addr[4:2]];
    if (flash_rd_req)
      fq <= fl[flash_rd_addr[7:2]];
    if (thr_wr_done && thr_wr_en_a)
      thr_copy_a <= thr_wr_data;
    if (thr_wr_done && thr_wr_en_b)
      thr_copy_b <= thr_wr_data;
  end
endmodule // pps_far
`default_nettype wire

// [pps_preboot_seq.v]
// Pre-boot sequencer between the system controller and processor cores.
// Assumes simple request/valid word reads from the boot configuration and
// the embedded flash, and external engines for copy, hash and signature.
`default_nettype none
`include "pps_defs.vh"

// Behaviour
// R1: Start only after design initialization completes; cores held until done.
// R2: Engineering-sample parts in controller suspend mode skip pre-boot entirely.
// R3: Power flash, init cache repair, authenticate if secure, then hand over.
// R4: Two-bit boot mode: 0 idle, 1 non-secure, 2 user secure, 3 factory.
// R5: Boot mode fixed by programmed configuration, never changed at run time.
// R6: Idle or unconfigured: cores loop in boot ROM; config data ignored.
// R7: Boot vectors held until device reset or new configuration.
// R8: Non-secure mode releases cores at configured vectors, no authentication.
// R9: Non-secure vectors read at offsets 0,4,8,16,20, monitor core first.
// R10: User secure mode copies secure flash code into monitor core memory.
// R11: User secure config: start page at 0, 12-byte key at 4, one key.
// R12: User secure authentication failure may hold cores and raise boot-fail.
// R13: Factory mode reads and validates certificate before loading boot code.
// R14: Good signature releases cores; error holds reset, flags fabric.
// R15: Certificate offsets: address, length, vectors, options, version, serial.
// R16: Non-zero serial binding compared to device serial; mismatch fails.
// R17: With revocation on, versions below the threshold are rejected.
// R18: Option bit 0 raises threshold to certificate version after checks; the code raises it only with revocation on.
// R19: Threshold kept in redundant copies; a torn update leaves old or new.
// R20: Factory config: certificate address at 0, revocation enable at 4.
// R21: Boot-fail flag and held reset stay until next device reset.
module pps_preboot_seq #(
  parameter VEC_W = 32
) (
  input wire clk,
  input wire reset,
  input wire design_init_done,
  input wire es_part,
  input wire suspend_mode,
  input wire mss_configured,
  input wire [1:0] boot_mode_select,
  output reg cfg_rd_req,
  output reg [7:0] cfg_rd_addr,
  input wire cfg_rd_valid,
  input wire [31:0] boot_config_data,
  output reg flash_rd_req,
  output reg [31:0] flash_rd_addr,
  input wire flash_rd_valid,
  input wire [31:0] flash_rd_data,
  input wire [127:0] device_serial,
  output reg flash_power_up,
  input wire flash_ready,
  output reg cache_repair_start,
  input wire cache_repair_done,
  output reg copy_start,
  output reg copy_factory,
  output reg [7:0] secure_code_start_page,
  output reg [95:0] page_access_key,
  input wire copy_done,
  output reg user_auth_start,
  input wire user_auth_done,
  input wire user_auth_fail,
  output reg sig_check_start,
  input wire sig_check_done,
  input wire sig_check_error,
  input wire [63:0] thr_copy_a,
  input wire [63:0] thr_copy_b,
  input wire thr_valid_a,
  input wire thr_valid_b,
  output reg thr_wr_en_a,
  output reg thr_wr_en_b,
  output reg [63:0] thr_wr_data,
  input wire thr_wr_done,
  output reg [VEC_W-1:0] monitor_core_vector,
  output reg [VEC_W-1:0] app_core0_vector,
  output reg [VEC_W-1:0] app_core1_vector,
  output reg [VEC_W-1:0] app_core2_vector,
  output reg [VEC_W-1:0] app_core3_vector,
  output reg [31:0] image_base_address,
  output reg [31:0] image_length,
  output reg boot_rom_loop,
  output reg core_reset,
  output reg boot_fail,
  output reg preboot_done
);

  localparam S_WAIT = 4'h0;
  localparam S_PWR = 4'h1;
  localparam S_REPAIR = 4'h2;
  localparam S_DISPATCH = 4'h3;
  localparam S_CFG = 4'h4;
  localparam S_COPY = 4'h5;
  localparam S_UAUTH = 4'h6;
  localparam S_CERT = 4'h7;
  localparam S_CHECK = 4'h8;
  localparam S_SIG = 4'h9;
  localparam S_THR_A = 4'hA;
  localparam S_THR_B = 4'hB;
  localparam S_RUN = 4'hC;
  localparam S_FAIL = 4'hD;
  localparam S_IDLE = 4'hE;

  reg [3:0] state_q;
  reg [1:0] mode_q;
  reg [2:0] idx_q;
  reg req_q;
  reg [31:0] cert_base_q;
  reg rev_en_q;
  reg [7:0] options_q;
  reg [63:0] version_q;
  reg [127:0] serial_q;
  reg [7:0] cword_q;
  wire [63:0] threshold;
  wire cert_bad;

  // Non-secure vector offsets are not evenly spaced
  function [7:0] vec_offset;
    input [2:0] i;
    begin
      case (i)
        3'h0: vec_offset = `PPS_CFG_VEC0;
        3'h1: vec_offset = `PPS_CFG_VEC1;
        3'h2: vec_offset = `PPS_CFG_VEC2;
        3'h3: vec_offset = `PPS_CFG_VEC3;
        default: vec_offset = `PPS_CFG_VEC4;
      endcase
    end
  endfunction

  // Copy B is written last, so a valid A with a torn B means A is newest
  assign threshold = thr_valid_a ? thr_copy_a :
                     (thr_valid_b ? thr_copy_b : 64'h0); // R19

  assign cert_bad = ((serial_q != 128'h0) && (serial_q != device_serial))
                    || (rev_en_q && (version_q < threshold)); // R16 R17

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= S_WAIT;
      mode_q <= `PPS_MODE_IDLE;
      idx_q <= 3'h0;
      req_q <= 1'b0;
      cert_base_q <= 32'h0;
      rev_en_q <= 1'b0;
      options_q <= 8'h00;
      version_q <= 64'h0;
      serial_q <= 128'h0;
      cword_q <= 8'h00;
      cfg_rd_req <= 1'b0;
      cfg_rd_addr <= 8'h00;
      flash_rd_req <= 1'b0;
      flash_rd_addr <= 32'h0;
      flash_power_up <= 1'b0;
      cache_repair_start <= 1'b0;
      copy_start <= 1'b0;
      copy_factory <= 1'b0;
      secure_code_start_page <= 8'h00;
      page_access_key <= 96'h0;
      user_auth_start <= 1'b0;
      sig_check_start <= 1'b0;
      thr_wr_en_a <= 1'b0;
      thr_wr_en_b <= 1'b0;
      thr_wr_data <= 64'h0;
      monitor_core_vector <= {VEC_W{1'b0}}; // R7
      app_core0_vector <= {VEC_W{1'b0}};
      app_core1_vector <= {VEC_W{1'b0}};
      app_core2_vector <= {VEC_W{1'b0}};
      app_core3_vector <= {VEC_W{1'b0}};
      image_base_address <= 32'h0;
      image_length <= 32'h0;
      boot_rom_loop <= 1'b0;
      core_reset <= 1'b1; // R1
      boot_fail <= 1'b0;
      preboot_done <= 1'b0;
    end
    else
    begin
      cfg_rd_req <= 1'b0;
      flash_rd_req <= 1'b0;
      cache_repair_start <= 1'b0;
      copy_start <= 1'b0;
      user_auth_start <= 1'b0;
      sig_check_start <= 1'b0;
      case (state_q)
        S_WAIT:
          if (design_init_done) // R1
          begin
            // Mode latched once here; later changes of the input are unseen
            mode_q <= boot_mode_select; // R4 R5
            if (es_part && suspend_mode) // R2
              state_q <= S_IDLE;
            else
            begin
              flash_power_up <= 1'b1; // R3
              state_q <= S_PWR;
            end
          end
        S_PWR:
          if (flash_ready)
          begin
            cache_repair_start <= 1'b1; // R3
            state_q <= S_REPAIR;
          end
        S_REPAIR:
          if (cache_repair_done)
            state_q <= S_DISPATCH;
        S_DISPATCH:
        begin
          idx_q <= 3'h0;
          req_q <= 1'b0;
          if (!mss_configured || mode_q == `PPS_MODE_IDLE)
          begin
            boot_rom_loop <= 1'b1; // R6
            core_reset <= 1'b0;
            preboot_done <= 1'b1;
            state_q <= S_IDLE;
          end
          else
            state_q <= S_CFG;
        end
        S_CFG:
          if (!req_q)
          begin
            cfg_rd_req <= 1'b1;
            req_q <= 1'b1;
            if (mode_q == `PPS_MODE_NONSEC)
              cfg_rd_addr <= vec_offset(idx_q); // R9
            else
              cfg_rd_addr <= {3'h0, idx_q, 2'h0}; // R11 R20
          end
          else if (cfg_rd_valid)
          begin
            req_q <= 1'b0;
            idx_q <= idx_q + 3'h1;
            if (mode_q == `PPS_MODE_NONSEC)
            begin
              case (idx_q)
                3'h0: monitor_core_vector <= boot_config_data[VEC_W-1:0];
                3'h1: app_core0_vector <= boot_config_data[VEC_W-1:0];
                3'h2: app_core1_vector <= boot_config_data[VEC_W-1:0];
                3'h3: app_core2_vector <= boot_config_data[VEC_W-1:0];
                default: app_core3_vector <= boot_config_data[VEC_W-1:0];
              endcase
              if (idx_q == 3'h4)
              begin
                core_reset <= 1'b0; // R8
                preboot_done <= 1'b1;
                state_q <= S_RUN;
              end
            end
            else if (mode_q == `PPS_MODE_USEC)
            begin
              case (idx_q)
                3'h0: secure_code_start_page <= boot_config_data[7:0];
                3'h1: page_access_key[31:0] <= boot_config_data;
                3'h2: page_access_key[63:32] <= boot_config_data;
                default: page_access_key[95:64] <= boot_config_data;
              endcase
              if (idx_q == 3'h3)
              begin
                copy_factory <= 1'b0;
                copy_start <= 1'b1; // R10
                state_q <= S_COPY;
              end
            end
            else
            begin
              if (idx_q == 3'h0)
                cert_base_q <= boot_config_data; // R20
              else
              begin
                rev_en_q <= (boot_config_data != 32'h0); // R20
                cword_q <= 8'h00;
                state_q <= S_CERT;
              end
            end
          end
        S_COPY:
          if (copy_done)
          begin
            if (copy_factory)
            begin
              sig_check_start <= 1'b1; // R14
              state_q <= S_SIG;
            end
            else
            begin
              user_auth_start <= 1'b1; // R3
              state_q <= S_UAUTH;
            end
          end
        S_UAUTH:
          if (user_auth_done)
          begin
            if (user_auth_fail)
              state_q <= S_FAIL; // R12
            else
            begin
              core_reset <= 1'b0; // R10
              preboot_done <= 1'b1;
              state_q <= S_RUN;
            end
          end
        S_CERT:
          // Hash and signature words are left to the signature engine
          if (cword_q == `PPS_CERT_WORDS)
            state_q <= S_CHECK;
          else if (!req_q)
          begin
            flash_rd_req <= 1'b1; // R13
            flash_rd_addr <= cert_base_q + {22'h0, cword_q, 2'h0};
            req_q <= 1'b1;
          end
          else if (flash_rd_valid)
          begin
            req_q <= 1'b0;
            cword_q <= cword_q + 8'h01;
            case ({cword_q[5:0], 2'h0}) // R15
              `PPS_CERT_ADDR: image_base_address <= flash_rd_data;
              `PPS_CERT_LEN: image_length <= flash_rd_data;
              `PPS_CERT_VEC: monitor_core_vector <= flash_rd_data[VEC_W-1:0];
              8'h0C: app_core0_vector <= flash_rd_data[VEC_W-1:0];
              8'h10: app_core1_vector <= flash_rd_data[VEC_W-1:0];
              8'h14: app_core2_vector <= flash_rd_data[VEC_W-1:0];
              8'h18: app_core3_vector <= flash_rd_data[VEC_W-1:0];
              `PPS_CERT_OPT: options_q <= flash_rd_data[7:0];
              `PPS_CERT_VER: version_q[31:0] <= flash_rd_data;
              8'h24: version_q[63:32] <= flash_rd_data;
              `PPS_CERT_SER: serial_q[31:0] <= flash_rd_data;
              8'h2C: serial_q[63:32] <= flash_rd_data;
              8'h30: serial_q[95:64] <= flash_rd_data;
              8'h34: serial_q[127:96] <= flash_rd_data;
              default: ;
            endcase
          end
        S_CHECK:
          if (cert_bad)
            state_q <= S_FAIL; // R16 R17
          else
          begin
            copy_factory <= 1'b1;
            copy_start <= 1'b1; // R13
            state_q <= S_COPY;
          end
        S_SIG:
          if (sig_check_done)
          begin
            if (sig_check_error)
              state_q <= S_FAIL; // R14
            else if (rev_en_q && options_q[`PPS_OPT_RAISE] &&
                     version_q > threshold)
            begin
              thr_wr_data <= version_q; // R18
              thr_wr_en_a <= 1'b1; // R19
              state_q <= S_THR_A;
            end
            else
            begin
              core_reset <= 1'b0; // R14
              preboot_done <= 1'b1;
              state_q <= S_RUN;
            end
          end
        S_THR_A:
          if (thr_wr_done)
          begin
            thr_wr_en_a <= 1'b0;
            thr_wr_en_b <= 1'b1; // R19
            state_q <= S_THR_B;
          end
        S_THR_B:
          if (thr_wr_done)
          begin
            thr_wr_en_b <= 1'b0;
            core_reset <= 1'b0;
            preboot_done <= 1'b1;
            state_q <= S_RUN;
          end
        S_FAIL:
        begin
          core_reset <= 1'b1; // R21
          boot_fail <= 1'b1; // R12 R14 R21
        end
        S_RUN: ;
        S_IDLE: ;
        default: state_q <= S_WAIT;
      endcase
    end
  end

endmodule // pps_preboot_seq
`default_nettype wire

// [pps_tb.sv]
// Bench for the pre-boot sequencer: every boot mode and failure path.
// Assumes pps_far answers the sequencer; inputs change at falling edge.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic design_init_done = 1'b0, es_part = 1'b0, suspend_mode = 1'b0;
  logic mss_configured = 1'b1, slow = 1'b0, auth_bad = 1'b0, sig_bad = 1'b0;
  logic [1:0] boot_mode_select = 2'h0;
  logic [127:0] device_serial = 128'h0;
  wire cfg_rd_req, cfg_rd_valid, flash_rd_req, flash_rd_valid, flash_ready;
  wire [7:0] cfg_rd_addr, secure_code_start_page;
  wire [31:0] boot_config_data, flash_rd_addr, flash_rd_data, image_length;
  wire flash_power_up, cache_repair_start, cache_repair_done, copy_start;
  wire copy_factory, copy_done, user_auth_start, user_auth_done;
  wire user_auth_fail, sig_check_start, sig_check_done, sig_check_error;
  wire [63:0] thr_copy_a, thr_copy_b, thr_wr_data;
  wire thr_valid_a, thr_valid_b, thr_wr_en_a, thr_wr_en_b, thr_wr_done;
  wire [95:0] page_access_key;
  wire [31:0] monitor_core_vector, app_core0_vector, app_core1_vector;
  wire [31:0] app_core2_vector, app_core3_vector, image_base_address;
  wire boot_rom_loop, core_reset, boot_fail, preboot_done;
  int n_fail = 0;
  int checks = 0;
  int k, w;
  logic [39:0] seen;
  logic [63:0] thr, ver;
  logic [31:0] v [0:4];
  logic bad;
  always #10 clk = ~clk;
  pps_preboot_seq uut (.*);
  pps_far fm (.*);
  // Offsets of config reads, oldest first, all ones when none seen
  always @(posedge clk)
    if (cfg_rd_req)
      seen <= {seen[31:0], cfg_rd_addr};
  task chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task boot(input logic [1:0] m, input logic sl);
    @(negedge clk);
    reset = 1'b1;
    design_init_done = 1'b0;
    boot_mode_select = m;
    slow = sl;
    seen = '1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    design_init_done = 1'b1;
    @(negedge clk);
    // Mode is latched by now; a late change must not matter
    boot_mode_select = ~m;
    for (w = 0; w < 3000 && core_reset === 1'b1 && boot_fail !== 1'b1; w++)
      @(negedge clk);
    repeat (30) @(negedge clk);
  endtask
  task vecs;
    chk(monitor_core_vector, v[0]);
    chk(app_core0_vector, v[1]);
    chk(app_core1_vector, v[2]);
    chk(app_core2_vector, v[3]);
    chk(app_core3_vector, v[4]);
  endtask
  initial
  begin
    void'($urandom(98));
    for (k = 0; k < 8; k++)
      fm.cfg[k] = $urandom;
    es_part = 1'b1;
    suspend_mode = 1'b1;
    boot(2'h1, 1'b0);
    chk({flash_power_up, core_reset, preboot_done}, 3'h2);
    es_part = 1'b0;
    v = '{fm.cfg[0], fm.cfg[1], fm.cfg[2], fm.cfg[4], fm.cfg[5]};
    for (k = 0; k < 2; k++)
    begin
      boot(2'h1, k[0]);
      vecs;
      chk(seen, 40'h0004081014);
      chk({core_reset, boot_rom_loop, boot_fail}, 3'h0);
    end
    suspend_mode = 1'b0;
    for (k = 0; k < 2; k++)
    begin
      mss_configured = k[0];
      boot({1'b0, ~k[0]}, 1'b0);
      chk({boot_rom_loop, core_reset, boot_fail}, 3'h4);
      chk(seen, 40'hFFFFFFFFFF);
    end
    for (k = 0; k < 2; k++)
    begin
      auth_bad = k[0];
      boot(2'h2, k[0]);
      chk(secure_code_start_page, fm.cfg[0][7:0]);
      chk(page_access_key, {fm.cfg[3], fm.cfg[2], fm.cfg[1]});
      chk({copy_factory, core_reset, boot_fail}, {1'b0, k[0], k[0]});
    end
    device_serial = {$urandom, $urandom, $urandom, $urandom};
    fm.cfg[0] = 32'h00000100;
    // Cases: good, serial miss, serial match, old, raise, bad signature
    for (k = 0; k < 6; k++)
    begin
      for (w = 0; w < 64; w++)
        fm.fl[w] = $urandom;
      thr = {$urandom, 32'h00000010};
      ver = (k == 3) ? thr - 64'h1 : thr + 64'h1;
      {fm.fl[9], fm.fl[8]} = ver;
      {fm.fl[13], fm.fl[12], fm.fl[11], fm.fl[10]} =
        (k == 1) ? ~device_serial : (k == 2) ? device_serial : 128'h0;
      fm.fl[7][0] = (k == 4);
      fm.cfg[1] = (k >= 3) ? ($urandom | 32'h00000100) : 32'h0;
      fm.thr_copy_a = thr;
      fm.thr_copy_b = thr;
      sig_bad = (k == 5);
      bad = k[0];
      boot(2'h3, k[1]);
      for (w = 0; w < 5; w++)
        v[w] = fm.fl[w + 2];
      if (!bad)
      begin
        vecs;
        chk({copy_factory, image_base_address, image_length},
          {1'b1, fm.fl[0], fm.fl[1]});
      end
      chk({core_reset, boot_fail}, {bad, bad});
      chk(fm.thr_copy_b, (k == 4) ? ver : thr);
      chk(fm.thr_copy_a, (k == 4) ? ver : thr);
    end
    test_done;
  end
  initial
  begin
    #2000000;
    n_fail++;
    test_done;
  end
endmodule // tb
`default_nettype wire
